// *** hsc_health_cal.sv ***
// Health word assembly, failure pin, iron calibration sequencer and packet transmitter.
// Assumes one 40 MHz clock, a pad pull-up on the calibration pin and static baud select.
`timescale 1ns/1ps
// What this block does
// - Failure pin goes high whenever the unit is in failure.
// - While calibration pin is low, magnetometer samples are collected.
// - When the pin releases, hard and soft iron values are computed.
// - Calibration pin pulled up; an open pin reads inactive.
// - Characters are one start, eight data, one stop bit, no parity.
// - Angle words are signed, degrees equal value times 180 over 2^15.
// - Acceleration words: g equals value times 10 times 1.5 over 2^15.
// - Rate words: deg/s equals value times 800 times 1.5 over 2^15.
// - Each measurement travels as a signed 16-bit two's complement word.
// - Health bit 0 marks an unrecoverable failure.
// - Bit 1 soft condition; beyond 2100 packets, bit 0 and bit 1 latch.
// - Bit 2 set while the system is not ready.
// - Bit 3 set on power failure running from hold-up power.
// - Bit 4 set on a user serial port error.
// - Bit 5 set after a processor reset was detected.
// - Bit 6 set when the sensor calibration table is invalid.
// - Bit 8 set while a turn is detected.
// - Bits 10 and 9 carry the algorithm state code.
// - Bit 11 set while iron calibration is in progress.
// - Bit 12 set when stored iron calibration data is invalid.
// - Bit 13 set when the calibration result is unsatisfactory.
// - Every flag is active one; the word fills two packet bytes.
// - Packets start with AA then 55; words go MSB first.
// - Packets repeat at 25, 50, 100 or 200 per second by baud.
module hsc_health_cal #(
   parameter int BAUD_DIV_9600 = hsc_pkg::CLK_HZ / hsc_pkg::BAUD_9600,
   parameter int PKT_PER_25    = hsc_pkg::CLK_HZ / hsc_pkg::RATE_9600,
   parameter int PKT_PER_50    = hsc_pkg::CLK_HZ / hsc_pkg::RATE_19200,
   parameter int PKT_PER_100   = hsc_pkg::CLK_HZ / hsc_pkg::RATE_38400,
   parameter int PKT_PER_200   = hsc_pkg::CLK_HZ / hsc_pkg::RATE_57600
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // Configuration
   input  wire logic [1:0]          baud_sel,
   input  wire logic [15:0]         model_num,
   // Measurements and health conditions
   input  wire hsc_pkg::hsc_meas_t  meas,
   input  wire hsc_pkg::hsc_cond_t  cond,
   // Magnetometer samples and calibration pin
   input  wire hsc_pkg::hsc_mag_t   mag,
   input  wire logic                mag_valid,
   input  wire logic                cal_pin_n,
   // Calibration results
   output hsc_pkg::hsc_mag_t        hard_iron,
   output hsc_pkg::hsc_mag_t        soft_span,
   output logic                     cal_done,
   // Health and failure pin (open collector)
   output logic [15:0]              health,
   output logic                     fail,
   output logic                     fail_pin_o,
   output logic                     fail_pin_oe,
   // Serial output
   output logic                     tx
);
   import hsc_pkg::*;

   logic                 rst_s1_reg, rst_sync_n;
   logic                 cal_s1_reg, cal_s2_reg, cal_s3_reg, cal_lvl_reg;
   hsc_cal_state_t       cal_state_reg;
   hsc_mag_t             min_reg, max_reg, hard_reg, span_reg;
   logic [7:0]           samp_cnt_reg;
   logic                 cal_poor_reg, cal_done_reg;
   logic [11:0]          soft_cnt_reg;
   logic                 soft_latch_reg;
   logic [15:0]          health_reg, health_next;
   logic [20:0]          per_cnt_reg, per_max;
   logic [12:0]          div_cnt_reg, div_max;
   logic                 pkt_start, pkt_active_reg, uart_busy_reg, tx_load;
   logic [4:0]           byte_idx_reg;
   logic [3:0]           bit_cnt_reg;
   logic [9:0]           shift_reg;
   logic [11:0][15:0]    snap_reg, snap_next;
   logic [15:0]          csum_reg, cur_word;
   logic [7:0]           cur_byte;

   // Signed min/max helpers shared by capture
   function automatic logic signed [15:0] smin(input logic signed [15:0] a, b);
      return (a < b) ? a : b;
   endfunction
   function automatic logic signed [15:0] smax(input logic signed [15:0] a, b);
      return (a > b) ? a : b;
   endfunction
   // Offset is the midpoint; 17-bit sum avoids overflow before the shift
   function automatic logic signed [15:0] mid(input logic signed [15:0] lo, hi);
      logic signed [16:0] s;
      s = 17'(lo) + 17'(hi);
      return s[16:1];
   endfunction
   // Byte sum stays below 16'hFFFF for 22 bytes, so the remainder is the sum
   function automatic logic [15:0] csum(input logic [11:0][15:0] w);
      logic [15:0] s;
      s = '0;
      for (int i = 1; i < 12; i++)
      begin
         s = s + 16'(w[i][15:8]) + 16'(w[i][7:0]);
      end
      return s;
   endfunction

   // ==========================================================
   // Reset release
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_sync_n <= rst_s1_reg;
      end
   end

   // ==========================================================
   // Calibration pin: reset to released so an open pin never starts a capture
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         cal_s1_reg  <= 1'b1;
         cal_s2_reg  <= 1'b1;
         cal_s3_reg  <= 1'b1;
         cal_lvl_reg <= 1'b1;
      end
      else
      begin
         cal_s1_reg <= cal_pin_n;
         cal_s2_reg <= cal_s1_reg;
         cal_s3_reg <= cal_s2_reg;
         if (cal_s2_reg == cal_s3_reg)
            cal_lvl_reg <= cal_s3_reg;
      end
   end

   // ==========================================================
   // Calibration sequencer
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         cal_state_reg <= CAL_IDLE;
         min_reg       <= '0;
         max_reg       <= '0;
         samp_cnt_reg  <= '0;
      end
      else
      begin
         case (cal_state_reg)
            CAL_IDLE:
            begin
               samp_cnt_reg <= '0;
               if (!cal_lvl_reg)
                  cal_state_reg <= CAL_CAPTURE;
            end
            CAL_CAPTURE:
            begin
               // First sample seeds the extremes
               if (mag_valid)
               begin
                  min_reg.x <= (samp_cnt_reg == '0) ? mag.x : smin(min_reg.x, mag.x);
                  min_reg.y <= (samp_cnt_reg == '0) ? mag.y : smin(min_reg.y, mag.y);
                  min_reg.z <= (samp_cnt_reg == '0) ? mag.z : smin(min_reg.z, mag.z);
                  max_reg.x <= (samp_cnt_reg == '0) ? mag.x : smax(max_reg.x, mag.x);
                  max_reg.y <= (samp_cnt_reg == '0) ? mag.y : smax(max_reg.y, mag.y);
                  max_reg.z <= (samp_cnt_reg == '0) ? mag.z : smax(max_reg.z, mag.z);
                  if (samp_cnt_reg != 8'hFF)
                     samp_cnt_reg <= samp_cnt_reg + 8'h01;
               end
               if (cal_lvl_reg)
                  cal_state_reg <= CAL_COMPUTE;
            end
            CAL_COMPUTE:
               cal_state_reg <= CAL_IDLE;
            default:
               cal_state_reg <= CAL_IDLE;
         endcase
      end
   end

   // Result registers; too few samples marks the result unsatisfactory
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         hard_reg     <= '0;
         span_reg     <= '0;
         cal_poor_reg <= 1'b0;
         cal_done_reg <= 1'b0;
      end
      else
      begin
         cal_done_reg <= (cal_state_reg == CAL_COMPUTE);
         if (cal_state_reg == CAL_COMPUTE)
         begin
            hard_reg.x   <= mid(min_reg.x, max_reg.x);
            hard_reg.y   <= mid(min_reg.y, max_reg.y);
            hard_reg.z   <= mid(min_reg.z, max_reg.z);
            span_reg.x   <= max_reg.x - min_reg.x;
            span_reg.y   <= max_reg.y - min_reg.y;
            span_reg.z   <= max_reg.z - min_reg.z;
            cal_poor_reg <= (samp_cnt_reg < CAL_MIN_SAMPLES);
         end
      end
   end

   // ==========================================================
   // Soft failure persistence, counted in packets
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         soft_cnt_reg   <= '0;
         soft_latch_reg <= 1'b0;
      end
      else if (pkt_start)
      begin
         if (!cond.soft_cond)
            soft_cnt_reg <= '0;
         else if (soft_cnt_reg >= SOFT_PERSIST_PKTS)
            soft_latch_reg <= 1'b1;
         else
            soft_cnt_reg <= soft_cnt_reg + 12'h001;
      end
   end

   // Health word; undefined positions stay zero
   always_comb
   begin
      health_next = '0;
      health_next[HB_HARD]      = cond.hard_fail | soft_latch_reg;
      health_next[HB_SOFT]      = cond.soft_cond | soft_latch_reg;
      health_next[HB_NOT_READY] = cond.not_ready;
      health_next[HB_POWER]     = cond.power_fail;
      health_next[HB_COMM]      = cond.comm_err;
      health_next[HB_REBOOT]    = cond.reboot;
      health_next[HB_CAL_TABLE] = cond.cal_table_bad;
      health_next[HB_TURN]      = cond.turn;
      health_next[HB_ALGO_HI:HB_ALGO_LO] = cond.algo;
      health_next[HB_MAG_BUSY]  = (cal_state_reg != CAL_IDLE);
      health_next[HB_MAG_BAD]   = cond.mag_cal_bad;
      health_next[HB_MAG_POOR]  = cond.mag_cal_poor | cal_poor_reg;
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         health_reg <= '0;
      else
         health_reg <= health_next;
   end

   // ==========================================================
   // Packet period and baud divisor by configured rate
   always_comb
   begin
      case (baud_sel)
         SEL_9600:  begin per_max = 21'(PKT_PER_25);  div_max = 13'(BAUD_DIV_9600);  end
         SEL_19200: begin per_max = 21'(PKT_PER_50);  div_max = 13'(BAUD_DIV_19200); end
         SEL_38400: begin per_max = 21'(PKT_PER_100); div_max = 13'(BAUD_DIV_38400); end
         default:   begin per_max = 21'(PKT_PER_200); div_max = 13'(BAUD_DIV_57600); end
      endcase
   end

   // Free running period timer; a tick during a packet is skipped, never queued
   assign pkt_start = (per_cnt_reg == '0) && !pkt_active_reg;
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         per_cnt_reg <= '0;
      else if (per_cnt_reg >= per_max - 21'h00_0001)
         per_cnt_reg <= '0;
      else
         per_cnt_reg <= per_cnt_reg + 21'h00_0001;
   end

   // Snapshot of the signed words at packet start keeps one packet coherent
   assign snap_next = {health_reg, model_num,
                       meas.acc_z, meas.acc_y, meas.acc_x,
                       meas.yaw_rate, meas.pitch_rate, meas.roll_rate,
                       meas.yaw, meas.pitch, meas.roll, PKT_HEADER};
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         snap_reg       <= '0;
         csum_reg       <= '0;
         pkt_active_reg <= 1'b0;
         byte_idx_reg   <= '0;
      end
      else
      begin
         if (pkt_start)
         begin
            snap_reg       <= snap_next;
            csum_reg       <= csum(snap_next);
            pkt_active_reg <= 1'b1;
            byte_idx_reg   <= '0;
         end
         else if (tx_load)
         begin
            if (byte_idx_reg == PKT_LAST)
               pkt_active_reg <= 1'b0;
            else
               byte_idx_reg <= byte_idx_reg + 5'h01;
         end
      end
   end

   // Even index is the high byte of each word
   assign cur_word = (byte_idx_reg >= PKT_CSUM_HI) ? csum_reg : snap_reg[byte_idx_reg[4:1]];
   assign cur_byte = byte_idx_reg[0] ? cur_word[7:0] : cur_word[15:8];
   assign tx_load  = pkt_active_reg && !uart_busy_reg;

   // ==========================================================
   // Character shifter, LSB first, line idles high
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         shift_reg     <= UART_IDLE;
         uart_busy_reg <= 1'b0;
         div_cnt_reg   <= '0;
         bit_cnt_reg   <= '0;
      end
      else if (tx_load)
      begin
         shift_reg     <= {1'b1, cur_byte, 1'b0};
         uart_busy_reg <= 1'b1;
         div_cnt_reg   <= '0;
         bit_cnt_reg   <= '0;
      end
      else if (uart_busy_reg)
      begin
         if (div_cnt_reg >= div_max - 13'h0001)
         begin
            div_cnt_reg <= '0;
            shift_reg   <= {1'b1, shift_reg[9:1]};
            if (bit_cnt_reg == UART_LAST_BIT)
               uart_busy_reg <= 1'b0;
            else
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         else
            div_cnt_reg <= div_cnt_reg + 13'h0001;
      end
   end

   // ==========================================================
   // Outputs; the pin is pulled low while healthy, released on failure
   assign fail        = health_reg[HB_HARD] | health_reg[HB_SOFT];
   assign fail_pin_o  = 1'b0;
   assign fail_pin_oe = !fail;
   assign health      = health_reg;
   assign tx          = shift_reg[0];
   assign hard_iron   = hard_reg;
   assign soft_span   = span_reg;
   assign cal_done    = cal_done_reg;

   // ==========================================================
   // Checks
   a_fail_pin_rel: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      health[HB_HARD] |-> !fail_pin_oe) else $error("fail pin not released");
   a_undef_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      health[7] == 1'b0 && health[15:14] == 2'b00) else $error("undefined bit set");
   a_soft_latch: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      soft_latch_reg |=> soft_latch_reg && health[HB_HARD] && health[HB_SOFT])
      else $error("soft latch lost");
   a_cal_start: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      cal_state_reg == CAL_IDLE && !cal_lvl_reg |=> cal_state_reg == CAL_CAPTURE)
      else $error("capture not started");
   a_cal_finish: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      cal_state_reg == CAL_CAPTURE && cal_lvl_reg |=> cal_state_reg == CAL_COMPUTE ##1
      cal_done && cal_state_reg == CAL_IDLE) else $error("compute not run");
   a_cal_busy: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      cal_state_reg != CAL_IDLE |=> health[HB_MAG_BUSY]) else $error("busy bit missing");
   a_algo_code: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      ##1 health[HB_ALGO_HI:HB_ALGO_LO] == $past(cond.algo)) else $error("algo code wrong");
   a_start_bit: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      tx_load |=> !tx ##0 uart_busy_reg) else $error("no start bit");
   a_header_byte: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      pkt_start |=> cur_byte == PKT_HEADER[15:8]) else $error("header not first");
endmodule

// *** hsc_host_rx.sv ***
// Host side model: a serial receiver that collects the packet stream.
// Assumes the design's serial line idles high and bits last BIT_CYC clocks.
`timescale 1ns/1ps
module hsc_host_rx #(
   parameter int BIT_CYC = 8
) (
   // Clock and serial line
   input wire logic ref_clk,
   input wire logic tx
);
   // ==========================================================
   // Received bytes, start times and framing faults
   logic [7:0] rx_q[$];
   time        t_q[$];
   int         frame_err;
   logic [7:0] sh;
   initial frame_err = 0;
   // Sample mid-bit so edge skew cannot flip a bit; start, 8 data LSB first, stop
   always
   begin
      @(negedge tx);
      t_q.push_back($time);
      repeat (BIT_CYC / 2) @(posedge ref_clk);
      if (tx !== 1'b0) frame_err++;
      for (int b = 0; b < 8; b++)
      begin
         repeat (BIT_CYC) @(posedge ref_clk);
         sh[b] = tx;
      end
      repeat (BIT_CYC) @(posedge ref_clk);
      if (tx !== 1'b1) frame_err++;
      rx_q.push_back(sh);
   end
endmodule

// *** hsc_pkg.sv ***
// Constants, field layouts and carrier types for the health word and calibration block.
// Assumes a single 40 MHz system clock; every clock-cycle count is derived from CLK_HZ.
package hsc_pkg;
   // ==========================================================
   // Clock and serial timing
   localparam int CLK_HZ     = 40_000_000;
   localparam int BAUD_9600  = 9600;
   localparam int BAUD_19200 = 19200;
   localparam int BAUD_38400 = 38400;
   localparam int BAUD_57600 = 57600;
   localparam int RATE_9600  = 25;           // Packets per second at each baud
   localparam int RATE_19200 = 50;
   localparam int RATE_38400 = 100;
   localparam int RATE_57600 = 200;
   localparam int BAUD_DIV_19200 = CLK_HZ / BAUD_19200;
   localparam int BAUD_DIV_38400 = CLK_HZ / BAUD_38400;
   localparam int BAUD_DIV_57600 = CLK_HZ / BAUD_57600;
   localparam logic [1:0] SEL_9600  = 2'h0;
   localparam logic [1:0] SEL_19200 = 2'h1;
   localparam logic [1:0] SEL_38400 = 2'h2;
   localparam logic [1:0] SEL_57600 = 2'h3;
   localparam logic [3:0] UART_LAST_BIT = 4'h9;     // Start, 8 data, stop
   localparam logic [9:0] UART_IDLE     = 10'h3FF;
   // ==========================================================
   // Packet layout
   localparam logic [15:0] PKT_HEADER  = 16'hAA55;
   localparam logic [4:0]  PKT_LAST    = 5'h19;     // 26 bytes, index 25 last
   localparam logic [4:0]  PKT_CSUM_HI = 5'h18;
   // ==========================================================
   // Health word bit positions
   localparam int HB_HARD      = 0;
   localparam int HB_SOFT      = 1;
   localparam int HB_NOT_READY = 2;
   localparam int HB_POWER     = 3;
   localparam int HB_COMM      = 4;
   localparam int HB_REBOOT    = 5;
   localparam int HB_CAL_TABLE = 6;
   localparam int HB_TURN      = 8;
   localparam int HB_ALGO_LO   = 9;
   localparam int HB_ALGO_HI   = 10;
   localparam int HB_MAG_BUSY  = 11;
   localparam int HB_MAG_BAD   = 12;
   localparam int HB_MAG_POOR  = 13;
   localparam logic [11:0] SOFT_PERSIST_PKTS = 12'h0834;  // 2100 packets
   localparam logic [7:0]  CAL_MIN_SAMPLES   = 8'h10;
   // ==========================================================
   // Output scaling of the signed Q15 measurement words
   localparam int ANGLE_SCALE_DEG = 180;
   localparam int ACCEL_RANGE_G   = 10;
   localparam int RATE_RANGE_DPS  = 800;
   localparam int SCALE_FRAC_BITS = 15;
   // ==========================================================
   // Types
   typedef struct packed {
      logic signed [15:0] roll, pitch, yaw;
      logic signed [15:0] roll_rate, pitch_rate, yaw_rate;
      logic signed [15:0] acc_x, acc_y, acc_z;
   } hsc_meas_t;
   typedef struct packed {
      logic       hard_fail, soft_cond, not_ready, power_fail, comm_err;
      logic       reboot, cal_table_bad, turn;
      logic [1:0] algo;
      logic       mag_cal_bad, mag_cal_poor;
   } hsc_cond_t;
   typedef struct packed {
      logic signed [15:0] x, y, z;
   } hsc_mag_t;
   typedef enum logic [1:0] {
      CAL_IDLE    = 2'b00,
      CAL_CAPTURE = 2'b01,
      CAL_COMPUTE = 2'b10
   } hsc_cal_state_t;
endpackage

// *** testbench.sv ***
// Self-checking bench for the health word, failure pin, calibration and packets.
// Assumes shortened serial timing: 8 clocks a bit at 9600 baud, 2400 clocks a packet.
`timescale 1ns/1ps
module testbench;
   import hsc_pkg::*;
   localparam int BIT_CYC = 8;
   localparam int PKT_CYC = 2400;
   // ==========================================================
   // Signals
   logic ref_clk, rst_n, cal_low, mag_valid, cal_done, fail, fail_pin_o, fail_pin_oe, tx;
   logic [15:0] model_num, health;
   logic [1:0]  baud_sel;
   hsc_meas_t   meas;
   hsc_cond_t   cond;
   hsc_mag_t    mag, hard_iron, soft_span;
   int          failures, tests_run, cyc;
   // Pad pull-up: an undriven calibration pin reads high
   wire cal_pin_n = cal_low ? 1'b0 : 1'b1;
   // Open collector pin with the user's pull-up
   wire fail_pin = fail_pin_oe ? fail_pin_o : 1'b1;
   // ==========================================================
   // Design and host model
   hsc_health_cal #(.BAUD_DIV_9600(BIT_CYC), .PKT_PER_25(PKT_CYC), .PKT_PER_50(PKT_CYC),
      .PKT_PER_100(PKT_CYC), .PKT_PER_200(PKT_CYC)) i_hsc_health_cal (.ref_clk(ref_clk),
      .rst_n(rst_n), .baud_sel(baud_sel), .model_num(model_num), .meas(meas), .cond(cond),
      .mag(mag), .mag_valid(mag_valid), .cal_pin_n(cal_pin_n), .hard_iron(hard_iron),
      .soft_span(soft_span), .cal_done(cal_done), .health(health), .fail(fail),
      .fail_pin_o(fail_pin_o), .fail_pin_oe(fail_pin_oe), .tx(tx));
   hsc_host_rx #(.BIT_CYC(BIT_CYC)) i_hsc_host_rx (.ref_clk(ref_clk), .tx(tx));
   // ==========================================================
   // Clock and hang guard
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         failures++;
         end_of_test();
      end
   end
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One condition at a time; bit map follows the struct order from its LSB
   task automatic t_health();
      int          hb[12] = '{13, 12, 9, 10, 8, 6, 5, 4, 3, 2, 1, 0};
      logic [15:0] e;
      for (int i = 0; i < 12; i++)
      begin
         @(negedge ref_clk);
         cond = hsc_cond_t'(12'h001 << i);
         @(negedge ref_clk);
         e = 16'h0001 << hb[i];
         check(health, e);
         check(fail, e[0] | e[1]);
         check(fail_pin, e[0] | e[1]);
      end
      cond = '0;
   endtask
   // Two whole packets after an idle gap; bytes, checksum and spacing
   task automatic t_packet();
      logic [175:0] body;
      logic [15:0]  sum;
      logic [7:0]   e;
      int           k;
      @(negedge ref_clk);
      // -90 deg, 45 deg, 90 deg; 600 deg/s, -600, 0; 7.5 g, -7.5 g, 1 g rounded
      meas = {16'(-90 * 2**15 / 180), 16'(45 * 2**15 / 180), 16'(90 * 2**15 / 180),
              16'(600 * 2**15 / 1200), 16'(-600 * 2**15 / 1200), 16'h0000,
              16'(75 * 2**15 / 150), 16'(-75 * 2**15 / 150), 16'(10 * 2**15 / 150)};
      model_num = 16'hC3A5;
      cond = hsc_cond_t'(12'h218);
      k = 0;
      while (k < 40)
      begin
         @(posedge ref_clk);
         k = tx ? k + 1 : 0;
      end
      i_hsc_host_rx.rx_q.delete();
      i_hsc_host_rx.t_q.delete();
      k = 0;
      while (i_hsc_host_rx.rx_q.size() < 52 && k < 3 * PKT_CYC)
      begin
         @(posedge ref_clk);
         k++;
      end
      body = {meas, model_num, 16'h0504};
      sum = '0;
      for (int b = 0; b < 22; b++) sum += 16'(body[175 - 8 * b -: 8]);
      for (int b = 0; b < 52; b++)
      begin
         k = b % 26;
         e = k == 0 ? 8'hAA : k == 1 ? 8'h55 : k < 24 ? body[191 - 8 * k -: 8] :
             k == 24 ? sum[15:8] : sum[7:0];
         check(i_hsc_host_rx.rx_q[b], e);
      end
      check(i_hsc_host_rx.frame_err, 0);
      check(48'(i_hsc_host_rx.t_q[26] - i_hsc_host_rx.t_q[0]), PKT_CYC * 25);
      // Inputs only move on the falling edge
      @(negedge ref_clk);
      cond = '0;
   endtask
   // Capture n samples with the pin low, then release and check the results
   task automatic t_cal(input int n, input logic poor);
      logic signed [15:0] mn[3], mx[3], v[3];
      logic [47:0]        eh, es;
      int                 k;
      @(negedge ref_clk);
      mag = {16'sh7000, 16'sh7000, -16'sh7000};
      mag_valid = 1'b1;   // ignored outside capture
      @(negedge ref_clk);
      mag_valid = 1'b0;
      cal_low = 1'b1;
      k = 0;
      while (health[11] !== 1'b1 && k < 20)
      begin
         @(negedge ref_clk);
         k++;
      end
      check(health[11], 1'b1);
      for (int i = 0; i < n; i++)
      begin
         v[0] = 16'(i * 7 - 40);
         v[1] = 16'(-i * 300);
         v[2] = 16'(i * i + 5);
         for (int a = 0; a < 3; a++)
         begin
            if (i == 0 || v[a] < mn[a]) mn[a] = v[a];
            if (i == 0 || v[a] > mx[a]) mx[a] = v[a];
         end
         mag = {v[0], v[1], v[2]};
         mag_valid = 1'b1;
         @(negedge ref_clk);
         mag_valid = 1'b0;
         @(negedge ref_clk);
      end
      cal_low = 1'b0;
      k = 0;
      while (cal_done !== 1'b1 && k < 20)
      begin
         @(negedge ref_clk);
         k++;
      end
      for (int a = 0; a < 3; a++)
      begin
         eh[47 - 16 * a -: 16] = (mn[a] + mx[a]) >>> 1;
         es[47 - 16 * a -: 16] = mx[a] - mn[a];
      end
      check(cal_done, 1'b1);
      check(hard_iron, eh);
      check(soft_span, es);
      repeat (2) @(negedge ref_clk);
      check(health[11], 1'b0);
      check(health[13], poor);
   endtask
   // Fastest rate; first character 8'hAA stays low for start plus bit 0
   task automatic t_fast_baud();
      int k;
      // Longest high run inside a packet is under 100 cycles
      k = 0;
      while (k < 100)
      begin
         @(negedge ref_clk);
         k = tx ? k + 1 : 0;
      end
      baud_sel = SEL_57600;
      @(negedge tx);
      k = 0;
      while (tx === 1'b0 && k < 4000)
      begin
         @(negedge ref_clk);
         if (tx === 1'b0)
            k++;
      end
      check(k, 2 * BAUD_DIV_57600);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      cal_low = 1'b0;
      mag_valid = 1'b0;
      model_num = '0;
      meas = '0;
      baud_sel = SEL_9600;
      cond = '0;
      mag = '0;
      failures = 0;
      tests_run = 0;
      cyc = 0;
      repeat (12) @(negedge ref_clk);
      check({tx, health, fail_pin}, {1'b1, 16'h0000, 1'b0});
      rst_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      t_health();
      t_packet();
      t_cal(16, 1'b0);
      t_cal(3, 1'b1);
      t_fast_baud();
      end_of_test();
   end
endmodule
